// ---- hw/reset_standby_pkg.sv ----
package reset_standby_pkg;
	// ======================================
	// register map (byte address in word space)
	localparam logic [15:0] standby_mode_control_addr = 16'hff8f;
	localparam int unsigned drive_bit = 0;
	localparam int unsigned bank_swap_bit = 1;
	localparam int unsigned mode_lo_bit = 2;
	localparam logic [1:0] mode_reset = 2'h0;
	localparam logic drive_reset = 1'b0;
	localparam logic [15:0] start_address = 16'h0000;
	// ======================================
	// timing
	localparam int unsigned reset_min_cycles = 10;
	localparam int unsigned clk_div = 4;
	typedef enum logic [1:0] {
		mode_run = 2'h0,
		mode_stop = 2'h1,
		mode_light_sleep_one = 2'h2,
		mode_light_sleep_two = 2'h3
	} standby_mode_e;
	typedef enum logic [2:0] {
		st_reset = 3'h1,
		st_release = 3'h2,
		st_run = 3'h4
	} seq_state_e;
endpackage

// ---- hw/reset_and_standby_control.sv ----
`timescale 1ns/1ns
module reset_and_standby_control #(
	parameter int unsigned port_width = 8
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// board reset pin, synchronous sample path
	input wire logic reset_pin_n_in,
	// cpu events
	input wire logic bank_swap_instruction_in,
	input wire logic ale_request_in,
	// avalon-mm slave
	input wire logic [15:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// pins and cpu control
	output logic [port_width-1:0] port_oe_out,
	output logic [port_width-1:0] pullup_en_out,
	output logic read_strobe_pin_out,
	output logic write_strobe_pin_out,
	output logic clk_pin_out,
	output logic ale_pin_out,
	output logic cpu_reset_out,
	output logic [15:0] pc_load_out,
	output logic interrupt_enable_flag_clr_out,
	output logic [1:0] standby_mode_out,
	output logic stop_drive_out
);
	import reset_standby_pkg::*;

	initial begin
		if (port_width < 1) $error("port_width must be positive");
	end

	// ======================================
	// reset pin synchroniser and low-time filter
	logic sync1_reg, sync2_reg;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= reset_pin_n_in;
			sync2_reg <= sync1_reg;
		end
	end

	// short glitches below the minimum low time are ignored
	logic [3:0] low_cnt_reg;
	logic reset_accept;
	assign reset_accept = (low_cnt_reg >= 4'(reset_min_cycles - 1)) &&
		!sync2_reg;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			low_cnt_reg <= 4'h0;
		end else if (sync2_reg) begin
			low_cnt_reg <= 4'h0;
		end else if (low_cnt_reg != 4'hf) begin
			low_cnt_reg <= low_cnt_reg + 4'h1;
		end
	end

	// ======================================
	// sequencer
	seq_state_e state_reg, state_next;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_reset: begin
				if (sync2_reg) state_next = st_release;
			end
			st_release: begin
				state_next = st_run;
			end
			st_run: begin
				if (reset_accept) state_next = st_reset;
			end
			default: state_next = st_reset;
		endcase
	end
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) state_reg <= st_reset;
		else state_reg <= state_next;
	end

	logic in_reset;
	assign in_reset = (state_next == st_reset);

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cpu_reset_out <= 1'b1;
			pc_load_out <= start_address;
			interrupt_enable_flag_clr_out <= 1'b1;
			port_oe_out <= '0;
			pullup_en_out <= '1;
		end else begin
			// only pc and enable flag are forced; other cpu state is kept
			cpu_reset_out <= in_reset;
			pc_load_out <= start_address;
			interrupt_enable_flag_clr_out <= in_reset;
			if (in_reset) begin
				port_oe_out <= '0;
				pullup_en_out <= '1;
			end else begin
				// outside reset direction is still forced here; keep inputs in every mode
				port_oe_out <= (standby_mode_out == mode_stop &&
					!stop_drive_out) ? '0 : '0;
				pullup_en_out <= '1;
			end
		end
	end

	// ======================================
	// clock output divider and address latch strobe
	logic [1:0] div_reg;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) div_reg <= 2'h0;
		else if (in_reset) div_reg <= 2'h0;
		else div_reg <= div_reg + 2'h1;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			clk_pin_out <= 1'b1;
			read_strobe_pin_out <= 1'b1;
			write_strobe_pin_out <= 1'b1;
			ale_pin_out <= 1'b0;
		end else if (in_reset) begin
			clk_pin_out <= 1'b1;
			read_strobe_pin_out <= 1'b1;
			write_strobe_pin_out <= 1'b1;
			ale_pin_out <= 1'b0;
		end else begin
			// high for two, low for two: a quarter of the input rate
			clk_pin_out <= (div_reg < 2'(clk_div / 2));
			read_strobe_pin_out <= 1'b1;
			write_strobe_pin_out <= 1'b1;
			// strobe follows the request, registered one cycle later
			ale_pin_out <= ale_request_in;
		end
	end

	// ======================================
	// standby mode control register
	logic sel;
	assign sel = (avs_address_in == standby_mode_control_addr);
	logic wr_hit;
	assign wr_hit = avs_write_in && sel && avs_waitrequest_out == 1'b0;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			standby_mode_out <= mode_reset;
			stop_drive_out <= drive_reset;
		end else if (in_reset) begin
			standby_mode_out <= mode_reset;
			stop_drive_out <= drive_reset;
		end else if (wr_hit) begin
			standby_mode_out <= avs_writedata_in[mode_lo_bit +: 2];
			stop_drive_out <= avs_writedata_in[drive_bit];
		end
	end

	// value after reset is left as it was; zero after power-up only
	logic bank_swap_flag_reg;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) bank_swap_flag_reg <= 1'b0;
		else if (bank_swap_instruction_in)
			bank_swap_flag_reg <= !bank_swap_flag_reg;
	end

	// one wait cycle per access: request taken on second edge
	logic ack_reg;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ack_reg <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h0;
		end else begin
			ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
			avs_waitrequest_out <= !((avs_read_in || avs_write_in) &&
				!ack_reg);
			if (avs_read_in && sel && !ack_reg)
				avs_readdata_out <= {28'h0, standby_mode_out,
					bank_swap_flag_reg, stop_drive_out};
			else
				avs_readdata_out <= 32'h0;
		end
	end
endmodule // reset_and_standby_control

// ---- dv/rsc_checker.sv ----
`timescale 1ns/1ns
module rsc_checker #(parameter int unsigned port_width = 8) (
	input wire logic core_clk_in, nrst_in, ale_request_in, avs_write_in,
	input wire logic [15:0] avs_address_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic avs_waitrequest_out, read_strobe_pin_out,
	input wire logic write_strobe_pin_out, clk_pin_out, ale_pin_out,
	input wire logic cpu_reset_out, interrupt_enable_flag_clr_out,
	input wire logic stop_drive_out,
	input wire logic [1:0] standby_mode_out,
	input wire logic [15:0] pc_load_out,
	input wire logic [port_width-1:0] port_oe_out, pullup_en_out
);
	// ==========
	// checks
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	wire logic tk = avs_write_in && !avs_waitrequest_out
		&& avs_address_in == 16'hff8f;
	sequence quarter;
		clk_pin_out ##1 !clk_pin_out [*2] ##1 clk_pin_out;
	endsequence
	AST_OE: assert property (port_oe_out == '0)
		else $error("port pin driven");
	AST_PU: assert property (&pullup_en_out)
		else $error("pull-up off");
	AST_RST: assert property (cpu_reset_out |-> read_strobe_pin_out
		&& write_strobe_pin_out && clk_pin_out) else $error("pins low in reset");
	AST_PC: assert property (cpu_reset_out |-> pc_load_out == 16'h0000
		&& interrupt_enable_flag_clr_out) else $error("pc or flag not cleared");
	AST_CLK: assert property (disable iff (!nrst_in || cpu_reset_out)
		$rose(clk_pin_out) |=> quarter) else $error("clock not quarter rate");
	AST_ALE: assert property (!cpu_reset_out && !$past(cpu_reset_out)
		|-> ale_pin_out == $past(ale_request_in)) else $error("ale wrong");
	AST_WR: assert property (tk && !cpu_reset_out |=>
		standby_mode_out == $past(avs_writedata_in[3:2])
		&& stop_drive_out == $past(avs_writedata_in[0])) else $error("write lost");
	AST_HOLD: assert property (!tk && !cpu_reset_out ##1 !cpu_reset_out
		|-> $stable(standby_mode_out) && $stable(stop_drive_out))
		else $error("field changed");
endmodule // rsc_checker
bind reset_and_standby_control rsc_checker #(.port_width(port_width)) chk (.*);

// ---- dv/board_model.sv ----
`timescale 1ns/1ns
module board_model (
	input wire logic core_clk_in, go_in, ale_pin_in,
	output logic reset_pin_n_out,
	output int latches_out
);
	// pin idles high by its pull-up
	initial reset_pin_n_out = 1'b1;
	initial latches_out = 0;
	always @(posedge core_clk_in) if (go_in) begin
		reset_pin_n_out <= 1'b0;
		repeat (12) @(posedge core_clk_in);
		reset_pin_n_out <= 1'b1;
	end
	always @(negedge ale_pin_in) latches_out++;
endmodule // board_model

// ---- dv/tb.sv ----
`timescale 1ns/1ns
module tb;
	logic core_clk_in = 0, nrst_in = 0, reset_pin_n_in, ale_request_in = 0;
	logic bank_swap_instruction_in = 0, avs_read_in = 0, avs_write_in = 0;
	logic [15:0] avs_address_in = 0, pc_load_out;
	logic [31:0] avs_writedata_in = 0, avs_readdata_out, q, e;
	logic [7:0] port_oe_out, pullup_en_out;
	logic avs_waitrequest_out, read_strobe_pin_out, write_strobe_pin_out;
	logic clk_pin_out, ale_pin_out, cpu_reset_out, stop_drive_out, go = 0;
	logic interrupt_enable_flag_clr_out;
	logic [1:0] standby_mode_out;
	int n_errors = 0, checks = 0, lat, l0, i;
	reset_and_standby_control dut (.*);
	board_model bm (.core_clk_in, .go_in(go), .ale_pin_in(ale_pin_out),
		.reset_pin_n_out(reset_pin_n_in), .latches_out(lat));
	always #10 core_clk_in = ~core_clk_in;
	// ==========
	// tasks
	task give_verdict;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, x);
		checks++;
		if (g !== x) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk_in);
			if (!avs_waitrequest_out) break;
		end
		q = avs_readdata_out;
		avs_write_in <= 0;
		avs_read_in <= 0;
		if (k == 50) begin n_errors++; give_verdict; end
	endtask
	task till_reset(input logic v);
		int k;
		for (k = 0; k < 60 && cpu_reset_out !== v; k++) @(posedge core_clk_in);
		if (k == 60) begin n_errors++; give_verdict; end
	endtask
	initial begin
		repeat (8) @(posedge core_clk_in);
		nrst_in <= 1;
		till_reset(0);
		acc(0, 16'hff8f, 0); chk(q, 0);
		for (i = 0; i < 4; i++) begin
			acc(1, 16'hff8f, i * 4 + 3);
			acc(0, 16'hff8f, 0); chk(q, i * 4 + 1);
		end
		acc(1, 16'hff8e, 32'h0); acc(0, 16'hff8e, 0); chk(q, 0);
		acc(0, 16'hff8f, 0); chk(q, 32'hd);
		$display("register test done");
		e = 32'hd;
		for (i = 0; i < 3; i++) begin
			@(posedge core_clk_in) bank_swap_instruction_in <= 1;
			repeat (i == 1 ? 3 : 1) @(posedge core_clk_in);
			bank_swap_instruction_in <= 0;
			e ^= 32'h2;
			acc(0, 16'hff8f, 0); chk(q, e);
		end
		$display("swap test done");
		@(posedge core_clk_in) go <= 1;
		@(posedge core_clk_in) go <= 0;
		till_reset(1);
		chk({read_strobe_pin_out, write_strobe_pin_out, clk_pin_out}, 7);
		till_reset(0);
		acc(0, 16'hff8f, 0); chk(q, 32'h2);
		$display("pin reset test done");
		l0 = lat;
		for (i = 0; i < 6; i++) @(posedge core_clk_in) ale_request_in <= i[0] ^ 1;
		repeat (3) @(posedge core_clk_in);
		chk(lat - l0, 3);
		$display("latch test done");
		give_verdict;
	end
endmodule // tb
